//--- hdl/hv_fault_filter.sv
// persistence filter: one pulse when a short lasts the full count
`timescale 1ns/1ps
module hv_fault_filter #(
  parameter int unsigned CYCLES = 2000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  hv_fault_if.filt flt
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_TOP = CW'(CYCLES);
  localparam logic [CW-1:0] CNT_HIT = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // counter saturates so a steady short reports once; rearm restarts it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
    end else if (!flt.raw || flt.rearm) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_TOP) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign flt.hit = flt.raw && !flt.rearm && (cnt_q == CNT_HIT);

endmodule : hv_fault_filter

//--- hdl/hv_io_config_status.sv
// high-voltage configuration registers, live monitor and interrupt status bank
`timescale 1ns/1ps
module hv_io_config_status
  import hv_io_pkg::*;
#(
  parameter int unsigned LIN_SC_COUNT = LIN_SC_CYCLES,
  parameter int unsigned WAKE_SC_COUNT = WAKE_SC_CYCLES,
  parameter int unsigned WAKE_TMO_COUNT = WAKE_TMO_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic hv_irq_o,
  input wire logic lin_short_i,
  input wire logic wake_short_i,
  input wire logic thermal_i,
  input wire logic psm_low_i,
  input wire logic wake_level_i,
  input wire logic buf_en_i,
  input wire logic lowv_flag_i,
  output logic atten_en_o,
  output logic temp_mon_en_o,
  output logic temp_to_adc_o,
  output logic vch_short_o,
  output logic wake_input_en_o,
  output logic wake_pullup_o,
  output logic lin_enable_o,
  output logic wake_enable_o,
  output logic wake_drive_o,
  output logic [7:0] cfg0_o
);

  localparam int unsigned TW = $clog2(WAKE_TMO_COUNT + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(WAKE_TMO_COUNT - 1);

  typedef enum logic {
    TMO_IDLE,
    TMO_RUN
  } tmo_state_e;

  logic [7:0] cfg0_q;
  logic [7:0] cfg1_q;
  logic [7:0] sta_q;
  logic [7:0] sta_d;
  logic [7:0] sta_set;
  logic [7:0] mon;
  logic [7:0] mon_prev_q;
  logic [7:0] data_port_q;
  logic lin_sc_q;
  logic lin_off_q;
  logic wake_sc_q;
  logic wake_off_q;
  logic overtemp_q;
  logic wr_cfg0;
  logic wr_cfg1;
  logic rd_sta;
  logic rearm;
  logic hv_event;
  logic tmo_expire;
  logic [TW-1:0] tmo_cnt_q;
  tmo_state_e tmo_state_q;

  hv_fault_if lin_flt ();
  hv_fault_if wake_flt ();

  // command decode; writes take the value already held in the data port
  assign wr_cfg0 = cmd_wr_i && (cmd_i == CMD_WR_CFG0);
  assign wr_cfg1 = cmd_wr_i && (cmd_i == CMD_WR_CFG1);
  assign rd_sta = cmd_wr_i && (cmd_i == CMD_RD_STA);

  // pulse, not a level, so a fault after the write is caught again
  assign rearm = wr_cfg1 && data_port_q[CFG1_IO_REARM];

  assign lin_flt.raw = lin_short_i;
  assign lin_flt.rearm = rearm;
  assign wake_flt.raw = wake_short_i;
  assign wake_flt.rearm = rearm;

  hv_fault_filter #(
    .CYCLES(LIN_SC_COUNT)
  ) u_lin_filter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .flt(lin_flt)
  );

  hv_fault_filter #(
    .CYCLES(WAKE_SC_COUNT)
  ) u_wake_filter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .flt(wake_flt)
  );

  // configuration one
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg1_q <= CFG1_RESET;
    end else if (wr_cfg1) begin
      cfg1_q <= data_port_q;
    end
  end

  // configuration zero; the assert bit is also dropped by the timeout
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg0_q <= CFG0_RESET;
    end else if (wr_cfg0) begin
      cfg0_q <= data_port_q;
    end else if (tmo_expire) begin
      cfg0_q[CFG0_WAKE_ASSERT] <= 1'b0;
    end
  end

  // wake assert timeout
  assign tmo_expire = (tmo_state_q == TMO_RUN) && (tmo_cnt_q == TMO_LAST);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tmo_state_q <= TMO_IDLE;
      tmo_cnt_q <= '0;
    end else begin
      unique case (tmo_state_q)
        TMO_IDLE: begin
          tmo_cnt_q <= '0;
          if (wr_cfg0 && data_port_q[CFG0_WAKE_ASSERT] && !cfg1_q[CFG1_TMO_OFF]) begin
            tmo_state_q <= TMO_RUN;
          end
        end
        TMO_RUN: begin
          if (cfg1_q[CFG1_TMO_OFF] || tmo_expire) begin
            tmo_state_q <= TMO_IDLE;
            tmo_cnt_q <= '0;
          end else if (wr_cfg0) begin
            // a fresh assert restarts the window, a deassert ends it
            tmo_state_q <= data_port_q[CFG0_WAKE_ASSERT] ? TMO_RUN : TMO_IDLE;
            tmo_cnt_q <= '0;
          end else begin
            tmo_cnt_q <= tmo_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // LIN short flag; the clearing write wins, since the filter masks the hit in that cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lin_sc_q <= 1'b0;
    end else if (lin_flt.hit) begin
      lin_sc_q <= 1'b1;
    end else if (rearm) begin
      lin_sc_q <= 1'b0;
    end
  end

  // LIN driver disable only in active protection mode
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      lin_off_q <= 1'b0;
    end else if (lin_flt.hit && !cfg1_q[CFG1_LIN_PASSIVE]) begin
      lin_off_q <= 1'b1;
    end else if (rearm) begin
      lin_off_q <= 1'b0;
    end
  end

  // wake short flag
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wake_sc_q <= 1'b0;
    end else if (wake_flt.hit) begin
      wake_sc_q <= 1'b1;
    end else if (rearm) begin
      wake_sc_q <= 1'b0;
    end
  end

  // wake pin disable after a short or a thermal event
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wake_off_q <= 1'b0;
    end else if (wake_flt.hit || thermal_i) begin
      wake_off_q <= 1'b1;
    end else if (rearm) begin
      wake_off_q <= 1'b0;
    end
  end

  // over-temperature is held so a brief event is not missed
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      overtemp_q <= 1'b0;
    end else if (thermal_i) begin
      overtemp_q <= 1'b1;
    end else if (rearm) begin
      overtemp_q <= 1'b0;
    end
  end

  // live monitor view
  always_comb begin
    mon = 8'h00;
    mon[MON_WAKE_LEVEL] = cfg1_q[CFG1_WAKE_RDBK] && wake_level_i;
    mon[MON_OVERTEMP] = overtemp_q;
    mon[MON_BUF_EN] = buf_en_i;
    mon[MON_LOWV] = lowv_flag_i;
    mon[MON_LIN_SC] = lin_sc_q;
    mon[MON_WAKE_SC] = wake_sc_q;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mon_prev_q <= 8'h00;
    end else begin
      mon_prev_q <= mon;
    end
  end

  // status events: wake edges both ways, fault flags on their rise
  always_comb begin
    sta_set = 8'h00;
    sta_set[STA_WAKE_REQ] = cfg1_q[CFG1_WAKE_RDBK] &&
                            (mon[MON_WAKE_LEVEL] != mon_prev_q[MON_WAKE_LEVEL]);
    sta_set[STA_OVERTEMP] = mon[MON_OVERTEMP] && !mon_prev_q[MON_OVERTEMP];
    sta_set[STA_LIN_SC] = mon[MON_LIN_SC] && !mon_prev_q[MON_LIN_SC];
    sta_set[STA_WAKE_SC] = mon[MON_WAKE_SC] && !mon_prev_q[MON_WAKE_SC];
  end

  // a supply drop raises the interrupt too, so it snapshots like the latched events
  assign hv_event = (|sta_set) || (sta_d[STA_PSM] && !sta_q[STA_PSM]);

  // sticky bits; a set in the clearing cycle survives
  always_comb begin
    sta_d = sta_q;
    if (rearm) begin
      sta_d[STA_OVERTEMP] = 1'b0;
      sta_d[STA_LIN_SC] = 1'b0;
      sta_d[STA_WAKE_SC] = 1'b0;
    end
    if (rd_sta) begin
      sta_d[STA_WAKE_REQ] = 1'b0;
    end
    sta_d = sta_d | sta_set;
    // supply monitor bit is a live level, never latched
    sta_d[STA_PSM] = cfg0_q[CFG0_PSM_EN] && psm_low_i;
    sta_d[7:6] = 2'b00;
    sta_d[1] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sta_q <= STA_RESET;
    end else begin
      sta_q <= sta_d;
    end
  end

  // data port: interrupt snapshot beats a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      data_port_q <= DATA_RESET;
    end else if (hv_event) begin
      data_port_q <= sta_d;
    end else if (cmd_wr_i) begin
      unique case (cmd_i)
        CMD_RD_CFG0: data_port_q <= cfg0_q;
        CMD_RD_CFG1: data_port_q <= cfg1_q;
        CMD_RD_STA: data_port_q <= sta_q;
        CMD_RD_MON: data_port_q <= mon;
        default: data_port_q <= data_port_q;
      endcase
    end else if (data_wr_i) begin
      data_port_q <= data_i;
    end
  end

  assign data_o = data_port_q;
  assign hv_irq_o = |sta_q;

  // analog controls straight from configuration flops; the enables come from the fault disable flops
  assign atten_en_o = cfg1_q[CFG1_ATTEN_EN];
  assign temp_mon_en_o = cfg1_q[CFG1_TEMP_MON];
  assign temp_to_adc_o = cfg1_q[CFG1_TEMP_MON];
  assign vch_short_o = cfg1_q[CFG1_VCH_SHORT];
  assign wake_input_en_o = cfg1_q[CFG1_WAKE_RDBK];
  assign wake_pullup_o = cfg1_q[CFG1_WAKE_PULLUP];
  assign lin_enable_o = !lin_off_q;
  assign wake_enable_o = !wake_off_q;
  assign wake_drive_o = cfg0_q[CFG0_WAKE_ASSERT] && !wake_off_q;
  assign cfg0_o = cfg0_q;

endmodule : hv_io_config_status

//--- include/hv_fault_if.sv
// signals between the register bank and one short-circuit persistence filter
`timescale 1ns/1ps
interface hv_fault_if;
  logic raw;
  logic rearm;
  logic hit;
  modport filt (input raw, input rearm, output hit);
  modport bank (output raw, output rearm, input hit);
endinterface : hv_fault_if

//--- include/hv_io_pkg.sv
// constants for the high-voltage configuration and status register bank
package hv_io_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // indirect command codes written to the command port
  localparam logic [7:0] CMD_RD_CFG0 = 8'h00;
  localparam logic [7:0] CMD_WR_CFG0 = 8'h01;
  localparam logic [7:0] CMD_RD_CFG1 = 8'h02;
  localparam logic [7:0] CMD_WR_CFG1 = 8'h03;
  localparam logic [7:0] CMD_RD_STA = 8'h04;
  localparam logic [7:0] CMD_RD_MON = 8'h05;

  // reset values
  localparam logic [7:0] CFG0_RESET = 8'h00;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [7:0] STA_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // hv_config_one fields
  localparam int unsigned CFG1_ATTEN_EN = 7;
  localparam int unsigned CFG1_TEMP_MON = 6;
  localparam int unsigned CFG1_VCH_SHORT = 5;
  localparam int unsigned CFG1_WAKE_RDBK = 4;
  localparam int unsigned CFG1_IO_REARM = 3;
  localparam int unsigned CFG1_LIN_PASSIVE = 2;
  localparam int unsigned CFG1_TMO_OFF = 1;
  localparam int unsigned CFG1_WAKE_PULLUP = 0;

  // hv_config_zero fields used here
  localparam int unsigned CFG0_WAKE_ASSERT = 4;
  localparam int unsigned CFG0_PSM_EN = 3;

  // hv_live_monitor fields
  localparam int unsigned MON_WAKE_LEVEL = 7;
  localparam int unsigned MON_OVERTEMP = 6;
  localparam int unsigned MON_BUF_EN = 4;
  localparam int unsigned MON_LOWV = 3;
  localparam int unsigned MON_LIN_SC = 2;
  localparam int unsigned MON_WAKE_SC = 0;

  // hv_irq_status fields
  localparam int unsigned STA_PSM = 5;
  localparam int unsigned STA_WAKE_REQ = 4;
  localparam int unsigned STA_OVERTEMP = 3;
  localparam int unsigned STA_LIN_SC = 2;
  localparam int unsigned STA_WAKE_SC = 0;

  // persistence and timeout figures
  localparam int unsigned LIN_SC_TIME_NS = 20000;
  localparam int unsigned WAKE_SC_TIME_NS = 400000;
  localparam real WAKE_TMO_TIME_S = 1.3;

  // least times round up, the timeout rounds down
  localparam int unsigned LIN_SC_CYCLES = (LIN_SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_SC_CYCLES = (WAKE_SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_TMO_CYCLES = int'($floor(WAKE_TMO_TIME_S * 1.0e9 / CLK_PERIOD_NS + 0.001));

endpackage : hv_io_pkg

//--- verification/hv_io_checker.sv
// port assertions for the hv configuration and status bank
`timescale 1ns/1ps
module hv_io_checker
  import hv_io_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] data_o,
  input wire logic hv_irq_o,
  input wire logic lin_short_i,
  input wire logic wake_short_i,
  input wire logic thermal_i,
  input wire logic temp_mon_en_o,
  input wire logic vch_short_o,
  input wire logic wake_pullup_o,
  input wire logic lin_enable_o,
  input wire logic wake_enable_o,
  input wire logic wake_drive_o,
  input wire logic [7:0] cfg0_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic rearm_w;
  assign rearm_w = cmd_wr_i && cmd_i == CMD_WR_CFG1 && data_o[3];
  sequence cfg1_wr;
    cmd_wr_i && cmd_i == CMD_WR_CFG1;
  endsequence
  // the rearm strobe acts at the very edge that takes the write
  sequence rearm_late;
    $past(rearm_w);
  endsequence
  a_cfg1_fields: assert property (
    cfg1_wr |=> {temp_mon_en_o, vch_short_o, wake_pullup_o} == $past({data_o[6], data_o[5], data_o[0]}))
    else $error("cfg1 pins wrong");
  a_cfg0_write: assert property (
    cmd_wr_i && cmd_i == CMD_WR_CFG0 |=> cfg0_o == $past(data_o)) else $error("cfg0 wrong");
  a_irq_snapshot: assert property (
    $rose(hv_irq_o) |-> (data_o & 8'h3D) != 8'h00) else $error("no snapshot");
  a_lin_filter: assert property (
    $fell(lin_enable_o) |-> $past(lin_short_i, 2) && $past(lin_short_i, 4)) else $error("lin early");
  a_wake_filter: assert property (
    $fell(wake_enable_o) |-> $past(thermal_i) || $past(thermal_i, 2)
      || ($past(wake_short_i, 2) && $past(wake_short_i, 8))) else $error("wake early");
  a_lin_rearm: assert property (
    $rose(lin_enable_o) |-> rearm_late) else $error("lin rearm");
  a_wake_rearm: assert property (
    $rose(wake_enable_o) |-> rearm_late) else $error("wake rearm");
  a_drive_gate: assert property (
    !wake_enable_o |-> !wake_drive_o) else $error("wake driven");
endmodule : hv_io_checker
bind hv_io_config_status hv_io_checker u_chk (.*);

//--- verification/hv_sw_model.sv
// software model driving the command and data port
`timescale 1ns/1ps
module hv_sw_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_i,
  output logic cwr_o,
  output logic [7:0] cmd_o,
  output logic dwr_o,
  output logic [7:0] dat_o
);
  initial begin
    cwr_o = 1'b0;
    dwr_o = 1'b0;
    cmd_o = 8'hFF;
    dat_o = 8'h00;
  end
  // value first, then the command; released lines show the inverse
  task automatic put(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    dwr_o <= 1'b1;
    dat_o <= d;
    @(posedge clk_i);
    dwr_o <= 1'b0;
    dat_o <= ~d;
    cwr_o <= 1'b1;
    cmd_o <= c;
    @(posedge clk_i);
    cwr_o <= 1'b0;
    cmd_o <= ~c;
    @(negedge clk_i);
  endtask : put
  task automatic get(input logic [7:0] c, output logic [7:0] d);
    @(posedge clk_i);
    cwr_o <= 1'b1;
    cmd_o <= c;
    @(posedge clk_i);
    cwr_o <= 1'b0;
    cmd_o <= ~c;
    @(negedge clk_i);
    d = rd_i;
  endtask : get
endmodule : hv_sw_model

//--- verification/testbench.sv
// self-checking bench for the hv configuration and status bank
`timescale 1ns/1ps
module testbench
  import hv_io_pkg::*;
;
  logic clk_i, resetn_i, cmd_wr_i, data_wr_i, hv_irq_o, lin_short_i, wake_short_i, thermal_i;
  logic psm_low_i, wake_level_i, buf_en_i, lowv_flag_i, atten_en_o, temp_mon_en_o, temp_to_adc_o;
  logic vch_short_o, wake_input_en_o, wake_pullup_o, lin_enable_o, wake_enable_o, wake_drive_o;
  logic [7:0] cmd_i, data_i, data_o, cfg0_o, v;
  logic [31:0] seed = 32'hAD96FFBF;
  int bad_count, checks_done, m_cfg1, m_sta;
  // short counts keep the run brief
  hv_io_config_status #(.LIN_SC_COUNT(4), .WAKE_SC_COUNT(8), .WAKE_TMO_COUNT(16)) dut (.*);
  hv_sw_model sw (.clk_i(clk_i), .rd_i(data_o), .cwr_o(cmd_wr_i), .cmd_o(cmd_i), .dwr_o(data_wr_i), .dat_o(data_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wt
  task automatic fault(input logic [2:0] f, input int n);
    @(posedge clk_i);
    {lin_short_i, wake_short_i, thermal_i} <= f;
    repeat (n) @(posedge clk_i);
    {lin_short_i, wake_short_i, thermal_i} <= 3'b000;
    wt(3);
  endtask : fault
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    #20000;
    bad_count++;
    results();
  end
  initial begin
    resetn_i = 1'b0;
    {lin_short_i, wake_short_i, thermal_i, psm_low_i, wake_level_i, buf_en_i, lowv_flag_i} = 7'h00;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    chk("data", DATA_RESET, data_o);
    chk("enables", 8'h03, {6'h00, lin_enable_o, wake_enable_o});
    sw.get(CMD_RD_CFG1, v);
    chk("cfg1", CFG1_RESET, v);
    sw.get(CMD_RD_STA, v);
    chk("status", STA_RESET, v);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      m_cfg1 = int'(xs() & 32'hF5);
      sw.put(CMD_WR_CFG1, 8'(m_cfg1));
      v = {atten_en_o, temp_mon_en_o, vch_short_o, wake_input_en_o, temp_to_adc_o, 2'b00, wake_pullup_o};
      chk("pins", 8'((m_cfg1 & 8'hF1) | ((m_cfg1 >> 3) & 8'h08)), v);
      sw.get(CMD_RD_CFG1, v);
      chk("cfg1", 8'(m_cfg1), v);
    end
    $display("config test done");
    sw.put(CMD_WR_CFG1, 8'h00);
    fault(3'b100, 3);
    chk("lin glitch", 8'h01, 8'(lin_enable_o));
    fault(3'b100, 6);
    m_sta = 8'h04;
    chk("lin irq", 8'h02, {6'h00, hv_irq_o, lin_enable_o});
    chk("snapshot", 8'(m_sta), data_o);
    sw.get(CMD_RD_MON, v);
    chk("mon", 8'h04, v & 8'h05);
    sw.get(CMD_RD_STA, v);
    chk("status", 8'(m_sta), v);
    chk("pending", 8'h01, 8'(hv_irq_o));
    sw.put(CMD_WR_CFG1, 8'h08);
    wt(2);
    chk("rearm", 8'h01, {6'h00, hv_irq_o, lin_enable_o});
    sw.get(CMD_RD_MON, v);
    chk("mon", 8'h00, v & 8'h05);
    sw.put(CMD_WR_CFG1, 8'h04);
    fault(3'b100, 6);
    chk("passive", 8'h03, {6'h00, hv_irq_o, lin_enable_o});
    chk("snapshot", 8'h04, data_o);
    sw.put(CMD_WR_CFG1, 8'h0C);
    $display("lin test done");
    fault(3'b010, 7);
    chk("wake glitch", 8'h01, 8'(wake_enable_o));
    for (int i = 0; i < 2; i++) begin
      m_sta = i ? 8'h08 : 8'h01;
      fault(i ? 3'b001 : 3'b010, i ? 2 : 10);
      wt(4);
      chk("wake off", 8'h02, {6'h00, hv_irq_o, wake_enable_o});
      chk("snapshot", 8'(m_sta), data_o);
      sw.put(CMD_WR_CFG1, 8'h08);
      wt(2);
      chk("wake on", 8'h01, {6'h00, hv_irq_o, wake_enable_o});
    end
    $display("wake test done");
    sw.put(CMD_WR_CFG1, 8'h10);
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_i);
      wake_level_i <= i[0];
      wt(3);
      chk("edge", 8'h10, data_o);
      sw.get(CMD_RD_MON, v);
      chk("level", 8'(i << 7), v & 8'h80);
      sw.get(CMD_RD_STA, v);
      wt(1);
      chk("irq", 8'h00, 8'(hv_irq_o));
    end
    $display("readback test done");
    sw.put(CMD_WR_CFG1, 8'h00);
    sw.put(CMD_WR_CFG0, 8'h10);
    chk("drive", 8'h01, 8'(wake_drive_o));
    wt(11);
    chk("cfg0", 8'h10, cfg0_o);
    wt(6);
    chk("timeout", 8'h00, cfg0_o);
    sw.put(CMD_WR_CFG1, 8'h02);
    sw.put(CMD_WR_CFG0, 8'h10);
    wt(20);
    chk("no timeout", 8'h10, cfg0_o);
    $display("timeout test done");
    sw.put(CMD_WR_CFG0, 8'h08);
    sw.get(CMD_RD_CFG0, v);
    chk("cfg0 rd", 8'h08, v);
    @(posedge clk_i);
    {psm_low_i, buf_en_i, lowv_flag_i} <= 3'b111;
    wt(2);
    chk("psm irq", 8'h01, 8'(hv_irq_o));
    chk("psm snap", 8'h20, data_o);
    sw.get(CMD_RD_MON, v);
    chk("mon lv", 8'h18, v & 8'h18);
    @(posedge clk_i);
    psm_low_i <= 1'b0;
    wt(2);
    chk("psm off", 8'h00, 8'(hv_irq_o));
    $display("supply test done");
    results();
  end
endmodule : testbench
